// >>> logic/mbs_pkg.sv
// package of constants and types for the motion block sequencer
// Function
// - absolute mode targets measured from reference
// - relative adds to position or last target
// - target is signed 32 bit, default 65536
// - refuse start outside software limit window
// - block speed commanded, default 163840
// - gear modes take speed from master
// - accel and decel 1..2^31-1, default 327680
// - zero ramp time linear, up to 2000ms S
// - operation mode 1xx runs automatic sequence
// - start begins sequence at first block
// - delay expiry selects delay next block
// - events during delay end it early
// - event 1 beats event 2 after target
// - interrupt events abort running block
// - priority int1, int2, ev1, ev2, delay
// - next 1..32 is block, 0 ends
// - mode 11x restarts, 10x waits start edge
// - repetitions only relative or touch probe
// - delay before each repetition, events after
// - next values -1..-3 give fault actions, other negatives end
package mbs_pkg;
  localparam int          BLOCKS        = 32;
  localparam int          IDX_W         = 5;
  localparam int          NEXT_W        = 7;
  localparam logic [31:0] TARGET_RESET  = 32'h0001_0000;
  localparam logic [31:0] SPEED_RESET   = 32'h0002_8000;
  localparam logic [31:0] ACCEL_RESET   = 32'h0005_0000;
  localparam logic [31:0] RAMP_MAX_MS   = 32'h0000_07d0;
  localparam logic [3:0]  MODE_ABS      = 4'h0;
  localparam logic [3:0]  MODE_REL      = 4'h1;
  localparam logic [3:0]  MODE_TP_RISE  = 4'h2;
  localparam logic [3:0]  MODE_TP_FALL  = 4'h3;
  localparam int          CLOCK_HZ      = 100_000_000;
  localparam int          MS_NS         = 1_000_000;
  localparam int          CLK_NS        = 1_000_000_000 / CLOCK_HZ;
  localparam int          MS_CYCLES     = MS_NS / CLK_NS;
  localparam int          NEXT_END      = 0;
  localparam int          NEXT_EMSTOP   = -3;
  localparam int          NEXT_STOP     = -2;
  localparam int          NEXT_OFF      = -1;

  typedef enum logic [2:0] {
    MBS_IDLE  = 3'b000,
    MBS_RUN   = 3'b001,
    MBS_DELAY = 3'b010,
    MBS_DONE  = 3'b011,
    MBS_FAULT = 3'b100
  } mbs_state_t;

  typedef enum logic [1:0] {
    MBS_FLT_NONE   = 2'b00,
    MBS_FLT_EMSTOP = 2'b01,
    MBS_FLT_STOP   = 2'b10,
    MBS_FLT_OFF    = 2'b11
  } mbs_fault_t;
endpackage

// >>> logic/mbs_ms_tick.sv
// millisecond enable divider
`timescale 1ns/1ns
module mbs_ms_tick #(
  parameter int DIV = mbs_pkg::MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic clear,
  output logic      tick
);
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;

  always_comb begin
    if (clear || cnt_reg == 20'(DIV - 1)) begin
      cnt_next = 20'h0;
    end else begin
      cnt_next = cnt_reg + 20'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 20'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = !clear && cnt_reg == 20'(DIV - 1);
endmodule

// >>> logic/mbs_sequencer.sv
// motion block sequencer top: block table, transitions, target resolve
`timescale 1ns/1ns
module mbs_sequencer #(
  parameter int MS_DIV = mbs_pkg::MS_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      startPin,
  input  wire logic                      event1Pin,
  input  wire logic                      event2Pin,
  input  wire logic                      intEvent1Pin,
  input  wire logic                      intEvent2Pin,
  input  wire logic [2:0]                opMode,
  input  wire logic                      cfgWrite,
  input  wire logic [4:0]                cfgIndex,
  input  wire logic signed [31:0]        cfgTarget,
  input  wire logic signed [31:0]        cfgSpeed,
  input  wire logic [31:0]               cfgAccel,
  input  wire logic [31:0]               cfgDecel,
  input  wire logic [10:0]               cfgRiseMs,
  input  wire logic [10:0]               cfgFallMs,
  input  wire logic [3:0]                cfgMotionMode,
  input  wire logic                      cfgGear,
  input  wire logic [7:0]                cfgRepeats,
  input  wire logic [15:0]               cfgDelayMs,
  input  wire logic signed [6:0]         cfgNextDelay,
  input  wire logic signed [6:0]         cfgNextEv1,
  input  wire logic signed [6:0]         cfgNextEv2,
  input  wire logic signed [6:0]         cfgNextInt1,
  input  wire logic signed [6:0]         cfgNextInt2,
  input  wire logic signed [31:0]        limitLow,
  input  wire logic signed [31:0]        limitHigh,
  input  wire logic signed [31:0]        actualPosition,
  input  wire logic                      lastWasManualJogMove,
  input  wire logic signed [31:0]        masterSpeed,
  input  wire logic                      targetReached,
  output logic                           moveStart,
  output logic                           moveAbort,
  output logic signed [31:0]             cmdTarget,
  output logic signed [31:0]             cmdSpeed,
  output logic [31:0]                    cmdAccel,
  output logic [31:0]                    cmdDecel,
  output logic [10:0]                    cmdRiseMs,
  output logic [10:0]                    cmdFallMs,
  output logic                           cmdSCurve,
  output logic                           startRefused,
  output logic [5:0]                     activeBlock,
  output logic                           busy,
  output logic [1:0]                     faultAction
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic       startOld_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncA_reg    <= 5'h00;
      syncB_reg    <= 5'h00;
      startOld_reg <= 1'b0;
    end else begin
      syncA_reg    <= {intEvent2Pin, intEvent1Pin, event2Pin, event1Pin,
                       startPin};
      syncB_reg    <= syncA_reg;
      startOld_reg <= syncB_reg[0];
    end
  end
  logic startRise;
  logic ev1;
  logic ev2;
  logic int1;
  logic int2;
  assign startRise = syncB_reg[0] && !startOld_reg;
  assign ev1  = syncB_reg[1];
  assign ev2  = syncB_reg[2];
  assign int1 = syncB_reg[3];
  assign int2 = syncB_reg[4];

  // ***************************************************************
  // block table
  // ***************************************************************
  localparam int BLOCKS = mbs_pkg::BLOCKS;
  logic signed [31:0] tTarget [BLOCKS];
  logic signed [31:0] tSpeed  [BLOCKS];
  logic [31:0]        tAccel  [BLOCKS];
  logic [31:0]        tDecel  [BLOCKS];
  logic [10:0]        tRise   [BLOCKS];
  logic [10:0]        tFall   [BLOCKS];
  logic [3:0]         tMode   [BLOCKS];
  logic               tGear   [BLOCKS];
  logic [7:0]         tRep    [BLOCKS];
  logic [15:0]        tDelay  [BLOCKS];
  logic signed [6:0]  tNext   [BLOCKS][5];

  // table entries reset to defaults so an unprogrammed block still moves
  genvar g;
  generate
    for (g = 0; g < BLOCKS; g++) begin : gTable
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          tTarget[g] <= mbs_pkg::TARGET_RESET;
          tSpeed[g]  <= mbs_pkg::SPEED_RESET;
          tAccel[g]  <= mbs_pkg::ACCEL_RESET;
          tDecel[g]  <= mbs_pkg::ACCEL_RESET;
          tRise[g]   <= 11'h000;
          tFall[g]   <= 11'h000;
          tMode[g]   <= mbs_pkg::MODE_ABS;
          tGear[g]   <= 1'b0;
          tRep[g]    <= 8'h00;
          tDelay[g]  <= 16'h0000;
          for (int k = 0; k < 5; k++) begin
            tNext[g][k] <= 7'sh00;
          end
        end else if (cfgWrite && cfgIndex == 5'(g)) begin
          tTarget[g] <= cfgTarget;
          tSpeed[g]  <= cfgSpeed;
          // zero rates are out of range; clamp to the least legal value
          tAccel[g]  <= (cfgAccel[30:0] == 31'h0) ? 32'h1 :
                        {1'b0, cfgAccel[30:0]};
          tDecel[g]  <= (cfgDecel[30:0] == 31'h0) ? 32'h1 :
                        {1'b0, cfgDecel[30:0]};
          tRise[g]   <= (32'(cfgRiseMs) > mbs_pkg::RAMP_MAX_MS) ?
                        11'(mbs_pkg::RAMP_MAX_MS) : cfgRiseMs;
          tFall[g]   <= (32'(cfgFallMs) > mbs_pkg::RAMP_MAX_MS) ?
                        11'(mbs_pkg::RAMP_MAX_MS) : cfgFallMs;
          tMode[g]   <= cfgMotionMode;
          tGear[g]   <= cfgGear;
          tRep[g]    <= cfgRepeats;
          tDelay[g]  <= cfgDelayMs;
          tNext[g][0] <= cfgNextInt1;
          tNext[g][1] <= cfgNextInt2;
          tNext[g][2] <= cfgNextEv1;
          tNext[g][3] <= cfgNextEv2;
          tNext[g][4] <= cfgNextDelay;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // sequencer state
  // ***************************************************************
  mbs_pkg::mbs_state_t state_reg, state_next;
  logic [4:0]          idx_reg, idx_next;
  logic [7:0]          rep_reg, rep_next;
  logic [15:0]         dly_reg, dly_next;
  logic signed [31:0]  lastTarget_reg, lastTarget_next;
  logic                launch_reg, launch_next;
  logic                abort_reg, abort_next;
  logic                refuse_reg, refuse_next;
  logic [1:0]          fault_reg, fault_next;
  logic signed [31:0]  tgt_reg, tgt_next;
  logic                msTick;

  mbs_ms_tick #(
    .DIV (MS_DIV)
  ) uTick (
    .clock  (clock),
    .resetn (resetn),
    .clear  (state_reg != mbs_pkg::MBS_DELAY),
    .tick   (msTick)
  );

  logic               seqMode;
  logic               restartMode;
  logic               relLike;
  logic signed [31:0] resolved;
  logic signed [6:0]  pick;
  logic               take;
  assign seqMode     = opMode[2];
  assign restartMode = opMode[1];
  // repeats only count for modes whose target moves each pass
  assign relLike = tMode[idx_reg] == mbs_pkg::MODE_REL ||
                   tMode[idx_reg] == mbs_pkg::MODE_TP_RISE ||
                   tMode[idx_reg] == mbs_pkg::MODE_TP_FALL;

  always_comb begin
    state_next      = state_reg;
    idx_next        = idx_reg;
    rep_next        = rep_reg;
    dly_next        = dly_reg;
    lastTarget_next = lastTarget_reg;
    launch_next     = 1'b0;
    abort_next      = 1'b0;
    refuse_next     = 1'b0;
    fault_next      = fault_reg;
    tgt_next        = tgt_reg;
    resolved        = tgt_reg;
    pick            = 7'sh00;
    take            = 1'b0;
    unique case (state_reg)
      mbs_pkg::MBS_IDLE, mbs_pkg::MBS_DONE: begin
        // in 11x the finished sequence restarts without a new edge
        if (startRise ||
            (state_reg == mbs_pkg::MBS_DONE && seqMode && restartMode)) begin
          idx_next = 5'h00;
          pick     = 7'sh01;
          take     = 1'b1;
        end
      end
      mbs_pkg::MBS_RUN: begin
        if (seqMode && int1 && tNext[idx_reg][0] != 7'sh00) begin
          pick = tNext[idx_reg][0];
          take = 1'b1;
          abort_next = 1'b1;
        end else if (seqMode && int2 && tNext[idx_reg][1] != 7'sh00) begin
          pick = tNext[idx_reg][1];
          take = 1'b1;
          abort_next = 1'b1;
        end else if (targetReached) begin
          if (!seqMode) begin
            state_next = mbs_pkg::MBS_DONE;
          end else begin
            state_next = mbs_pkg::MBS_DELAY;
            dly_next   = tDelay[idx_reg];
          end
        end
      end
      mbs_pkg::MBS_DELAY: begin
        if (msTick && dly_reg != 16'h0000) begin
          dly_next = dly_reg - 16'h0001;
        end
        if (relLike && rep_reg != 8'h00) begin
          // events wait until the last repetition and its delay
          if (dly_reg == 16'h0000 || (msTick && dly_reg == 16'h0001)) begin
            rep_next = rep_reg - 8'h01;
            pick     = 7'(idx_reg) + 7'sh01;
            take     = 1'b1;
          end
        end else if (ev1 && tNext[idx_reg][2] != 7'sh00) begin
          pick = tNext[idx_reg][2];
          take = 1'b1;
        end else if (ev2 && tNext[idx_reg][3] != 7'sh00) begin
          pick = tNext[idx_reg][3];
          take = 1'b1;
        end else if (tDelay[idx_reg] != 16'h0000 && msTick &&
                     dly_reg == 16'h0001) begin
          pick = tNext[idx_reg][4];
          take = 1'b1;
        end else if (tDelay[idx_reg] == 16'h0000 &&
                     tNext[idx_reg][2] == 7'sh00 &&
                     tNext[idx_reg][3] == 7'sh00) begin
          state_next = mbs_pkg::MBS_DONE;
        end
      end
      mbs_pkg::MBS_FAULT: begin
        if (startRise) begin
          fault_next = 2'(mbs_pkg::MBS_FLT_NONE);
          idx_next   = 5'h00;
          pick       = 7'sh01;
          take       = 1'b1;
        end
      end
      default: begin
        state_next = mbs_pkg::MBS_IDLE;
      end
    endcase

    if (take) begin
      if (pick == 7'(mbs_pkg::NEXT_END)) begin
        state_next = mbs_pkg::MBS_DONE;
      end else if (pick == 7'(mbs_pkg::NEXT_EMSTOP)) begin
        state_next = mbs_pkg::MBS_FAULT;
        fault_next = 2'(mbs_pkg::MBS_FLT_EMSTOP);
        abort_next = 1'b1;
      end else if (pick == 7'(mbs_pkg::NEXT_STOP)) begin
        state_next = mbs_pkg::MBS_FAULT;
        fault_next = 2'(mbs_pkg::MBS_FLT_STOP);
        abort_next = 1'b1;
      end else if (pick == 7'(mbs_pkg::NEXT_OFF)) begin
        state_next = mbs_pkg::MBS_FAULT;
        fault_next = 2'(mbs_pkg::MBS_FLT_OFF);
        abort_next = 1'b1;
      end else if (pick < 7'sh00 || pick > 7'(mbs_pkg::BLOCKS)) begin
        state_next = mbs_pkg::MBS_DONE;
      end else begin
        if (5'(pick - 7'sh01) != idx_reg || state_reg != mbs_pkg::MBS_DELAY
            || !relLike) begin
          rep_next = tRep[5'(pick - 7'sh01)];
        end
        idx_next = 5'(pick - 7'sh01);
        // resolved here so no loop runs through a second process
        if (tMode[idx_next] == mbs_pkg::MODE_ABS) begin
          resolved = tTarget[idx_next];
        end else if (lastWasManualJogMove) begin
          resolved = 32'(actualPosition + tTarget[idx_next]);
        end else begin
          resolved = 32'(lastTarget_reg + tTarget[idx_next]);
        end
        if (resolved < limitLow || resolved > limitHigh) begin
          state_next  = mbs_pkg::MBS_IDLE;
          refuse_next = 1'b1;
        end else begin
          state_next      = mbs_pkg::MBS_RUN;
          launch_next     = 1'b1;
          tgt_next        = resolved;
          lastTarget_next = resolved;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= mbs_pkg::MBS_IDLE;
      idx_reg        <= 5'h00;
      rep_reg        <= 8'h00;
      dly_reg        <= 16'h0000;
      lastTarget_reg <= 32'sh0;
      launch_reg     <= 1'b0;
      abort_reg      <= 1'b0;
      refuse_reg     <= 1'b0;
      fault_reg      <= 2'(mbs_pkg::MBS_FLT_NONE);
      tgt_reg        <= 32'sh0;
    end else begin
      state_reg      <= state_next;
      idx_reg        <= idx_next;
      rep_reg        <= rep_next;
      dly_reg        <= dly_next;
      lastTarget_reg <= lastTarget_next;
      launch_reg     <= launch_next;
      abort_reg      <= abort_next;
      refuse_reg     <= refuse_next;
      fault_reg      <= fault_next;
      tgt_reg        <= tgt_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign moveStart    = launch_reg;
  assign moveAbort    = abort_reg;
  assign startRefused = refuse_reg;
  assign faultAction  = fault_reg;
  assign cmdTarget    = tgt_reg;
  assign busy         = state_reg == mbs_pkg::MBS_RUN ||
                        state_reg == mbs_pkg::MBS_DELAY;
  assign activeBlock  = busy ? 6'(idx_reg) + 6'h01 : 6'h00;
  assign cmdSpeed  = tGear[idx_reg] ? masterSpeed :
                     tSpeed[idx_reg];
  assign cmdAccel  = tAccel[idx_reg];
  assign cmdDecel  = tDecel[idx_reg];
  assign cmdRiseMs = tRise[idx_reg];
  assign cmdFallMs = tFall[idx_reg];
  assign cmdSCurve = tRise[idx_reg] != 11'h000 ||
                     tFall[idx_reg] != 11'h000;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence sIntHit;
    state_reg == mbs_pkg::MBS_RUN && seqMode && int1 &&
    tNext[idx_reg][0] != 7'sh00;
  endsequence
  property pIntAbort;
    @(posedge clock) disable iff (!resetn) sIntHit |=> moveAbort;
  endproperty
  int_abort_a: assert property (pIntAbort)
    else $error("interrupt did not abort block");
  start_first_a: assert property (@(posedge clock) disable iff (!resetn)
    state_reg == mbs_pkg::MBS_IDLE && startRise |=> idx_reg == 5'h00)
    else $error("start did not select first block");
  refuse_limit_a: assert property (@(posedge clock) disable iff (!resetn)
    moveStart |-> cmdTarget >= limitLow && cmdTarget <= limitHigh)
    else $error("move launched outside limits");
  scurve_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    cmdSCurve == (cmdRiseMs != 11'h000 || cmdFallMs != 11'h000))
    else $error("ramp shape flag wrong");
  gear_speed_a: assert property (@(posedge clock) disable iff (!resetn)
    tGear[idx_reg] |-> cmdSpeed == masterSpeed)
    else $error("gear block not on master speed");
  fault_state_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(state_reg == mbs_pkg::MBS_FAULT) |-> faultAction != 2'b00)
    else $error("fault without action");
  no_launch_idle_a: assert property (@(posedge clock) disable iff (!resetn)
    moveStart |-> state_reg == mbs_pkg::MBS_RUN)
    else $error("launch without running state");
  abs_target_a: assert property (@(posedge clock) disable iff (!resetn)
    moveStart && tMode[idx_reg] == mbs_pkg::MODE_ABS |->
    cmdTarget == tTarget[idx_reg])
    else $error("absolute target altered");
endmodule

// >>> dv/mbs_motion_partner.sv
// motion loop stand-in: answers each launch not aborted first with one reach pulse
`timescale 1ns/1ns
module mbs_motion_partner (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        moveStart,
  input  wire logic        moveAbort,
  input  wire logic [15:0] reachDelay,
  output logic             targetReached
);
  logic [15:0] count_reg;
  logic        armed_reg;
  // falling edge drive keeps the pulse settled at the sequencer's edge
  always @(negedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg     <= 16'h0000;
      armed_reg     <= 1'b0;
      targetReached <= 1'b0;
    end else begin
      targetReached <= 1'b0;
      if (moveStart) begin
        count_reg <= reachDelay;
        armed_reg <= 1'b1;
      end else if (moveAbort) begin
        armed_reg <= 1'b0;
      end else if (armed_reg && count_reg != 16'h0000) begin
        count_reg <= count_reg - 16'h0001;
      end else if (armed_reg) begin
        targetReached <= 1'b1;
        armed_reg     <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the motion block sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failCount++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam logic [3:0] ABS = mbs_pkg::MODE_ABS;
  localparam logic [3:0] REL = mbs_pkg::MODE_REL;
  logic clock = 1'b0, resetn = 1'b0, startPin = 1'b0, cfgWrite = 1'b0;
  logic event1Pin = 1'b0, event2Pin = 1'b0, cfgGear = 1'b0;
  logic intEvent1Pin = 1'b0, intEvent2Pin = 1'b0, lastWasManualJogMove = 1'b0;
  logic [2:0] opMode = 3'h0;
  logic [4:0] cfgIndex = 5'h00;
  logic signed [31:0] cfgTarget = 0, cfgSpeed = 0, actualPosition = 0;
  logic signed [31:0] masterSpeed = 0, lastTgt, cmdTarget, cmdSpeed;
  logic [31:0] cfgAccel = 32'h0, cfgDecel = 32'h0, cmdAccel, cmdDecel;
  logic [10:0] cfgRiseMs = 11'h0, cfgFallMs = 11'h0, cmdRiseMs, cmdFallMs;
  logic [3:0] cfgMotionMode = 4'h0;
  logic [7:0] cfgRepeats = 8'h00;
  logic [15:0] cfgDelayMs = 16'h0, reachDelay = 16'h0005;
  logic signed [6:0] cfgNextDelay = 0, cfgNextEv1 = 0, cfgNextEv2 = 0;
  logic signed [6:0] cfgNextInt1 = 0, cfgNextInt2 = 0;
  logic targetReached, moveStart, moveAbort, cmdSCurve, startRefused, busy;
  logic [5:0] activeBlock;
  logic [1:0] faultAction;
  logic signed [31:0] eT[32], eS[32];
  logic [31:0] eA[32], eD[32];
  logic [10:0] eR[32], eF[32];
  logic [3:0]  eM[32];
  logic        eG[32];
  int failCount = 0, nTests = 0, waited, t, i;

  always #5 clock = ~clock;

  mbs_sequencer #(.MS_DIV(10)) mbs_sequencer_inst (.clock(clock),
    .resetn(resetn), .startPin(startPin), .event1Pin(event1Pin),
    .event2Pin(event2Pin), .intEvent1Pin(intEvent1Pin),
    .intEvent2Pin(intEvent2Pin), .opMode(opMode), .cfgWrite(cfgWrite),
    .cfgIndex(cfgIndex), .cfgTarget(cfgTarget), .cfgSpeed(cfgSpeed),
    .cfgAccel(cfgAccel), .cfgDecel(cfgDecel), .cfgRiseMs(cfgRiseMs),
    .cfgFallMs(cfgFallMs), .cfgMotionMode(cfgMotionMode), .cfgGear(cfgGear),
    .cfgRepeats(cfgRepeats), .cfgDelayMs(cfgDelayMs),
    .cfgNextDelay(cfgNextDelay), .cfgNextEv1(cfgNextEv1),
    .cfgNextEv2(cfgNextEv2), .cfgNextInt1(cfgNextInt1),
    .cfgNextInt2(cfgNextInt2), .limitLow(-32'sd1000000),
    .limitHigh(32'sd1000000), .actualPosition(actualPosition),
    .lastWasManualJogMove(lastWasManualJogMove), .masterSpeed(masterSpeed),
    .targetReached(targetReached), .moveStart(moveStart),
    .moveAbort(moveAbort), .cmdTarget(cmdTarget), .cmdSpeed(cmdSpeed),
    .cmdAccel(cmdAccel), .cmdDecel(cmdDecel), .cmdRiseMs(cmdRiseMs),
    .cmdFallMs(cmdFallMs), .cmdSCurve(cmdSCurve),
    .startRefused(startRefused), .activeBlock(activeBlock), .busy(busy),
    .faultAction(faultAction));
  mbs_motion_partner mbs_motion_partner_inst (.clock(clock),
    .resetn(resetn), .moveStart(moveStart), .moveAbort(moveAbort),
    .reachDelay(reachDelay), .targetReached(targetReached));

  function automatic logic signed [31:0] resolve(input int b, input int pos,
      input logic manual_jog_move);
    if (eM[b-1] == ABS) return eT[b-1];
    return (manual_jog_move ? pos : lastTgt) + eT[b-1];
  endfunction

  // rates live in 1..2^31-1: top bit dropped, zero lifted to one
  function automatic logic [31:0] rate(input logic [31:0] v);
    return (v[30:0] == 31'h0) ? 32'h1 : {1'b0, v[30:0]};
  endfunction

  function automatic logic [10:0] ramp(input logic [10:0] v);
    return (v > 11'h7d0) ? 11'h7d0 : v;
  endfunction

  task automatic endOfTest();
    $display("TB: %0d compares, %0d mismatches", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cfg(input int b, input logic [3:0] mm, input int tg,
      input logic g, input int r, input int rp, input int dl, input int nd,
      input int n1, input int n2, input int i1, input int i2);
    @(negedge clock);
    {cfgIndex, cfgMotionMode, cfgTarget, cfgGear} = {5'(b - 1), mm, tg, g};
    {cfgRiseMs, cfgRepeats, cfgDelayMs} = {11'(r), 8'(rp), 16'(dl)};
    {cfgNextDelay, cfgNextEv1, cfgNextEv2} = {7'(nd), 7'(n1), 7'(n2)};
    {cfgNextInt1, cfgNextInt2} = {7'(i1), 7'(i2)};
    cfgSpeed = $urandom;
    cfgAccel = $urandom | 32'h8000_0001;
    cfgDecel = $urandom & 32'h8000_0003;
    cfgFallMs = 11'($urandom_range(0, 2047));
    {eT[b-1], eS[b-1], eA[b-1]} = {cfgTarget, cfgSpeed, cfgAccel};
    {eD[b-1], eF[b-1]} = {cfgDecel, cfgFallMs};
    {eR[b-1], eM[b-1], eG[b-1]} = {cfgRiseMs, mm, g};
    cfgWrite = 1'b1;
    @(negedge clock);
    cfgWrite = 1'b0;
  endtask

  // bounded wait for the next launch or refusal
  task automatic waitStart();
    waited = 0;
    do begin
      @(posedge clock);
      #1;
      waited++;
    end while (waited < 3000 && moveStart !== 1'b1 && startRefused !== 1'b1);
    if (waited == 3000) begin
      failCount++;
      endOfTest();
    end
  endtask

  task automatic startSeq();
    @(negedge clock);
    startPin = 1'b1;
    waitStart();
    @(negedge clock);
    startPin = 1'b0;
  endtask

  task automatic checkBlock(input int b, input int pos, input logic manual_jog_move);
    logic signed [31:0] e;
    e = resolve(b, pos, manual_jog_move);
    lastTgt = e;
    `CHK(moveStart, 1'b1)
    `CHK(activeBlock, 6'(b))
    `CHK(cmdTarget, e)
    `CHK(cmdSpeed, eG[b-1] ? masterSpeed : eS[b-1])
    `CHK(cmdAccel, rate(eA[b-1]))
    `CHK(cmdDecel, rate(eD[b-1]))
    `CHK(cmdRiseMs, ramp(eR[b-1]))
    `CHK(cmdFallMs, ramp(eF[b-1]))
    `CHK(cmdSCurve, eR[b-1] != 11'h000 || eF[b-1] != 11'h000)
  endtask

  initial begin
    void'($urandom(32'h83bb));
    masterSpeed = $urandom;
    t = $urandom_range(1000, 90000);
    repeat (20) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    // ************ defaults and refusal ************
    startSeq();
    `CHK(cmdTarget, 32'sh0001_0000)
    `CHK(cmdSpeed, mbs_pkg::SPEED_RESET)
    `CHK(cmdAccel, mbs_pkg::ACCEL_RESET)
    `CHK(cmdDecel, mbs_pkg::ACCEL_RESET)
    repeat (30) @(negedge clock);
    cfg(1, ABS, 1000001, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    startSeq();
    `CHK({startRefused, moveStart}, 2'b10)
    $display("TB: defaults and refusal done");
    // ************ delay, events, interrupts, fault ************
    opMode = 3'b100;
    cfg(1, ABS, 1000000, 0, 0, 0, 3, 2, 0, 0, 0, 0);
    cfg(2, REL, -t, 1, 2047, 0, 0, 0, 3, 4, 0, 0);
    cfg(3, ABS, t, 0, $urandom_range(1, 2000), 0, 0, 0, 0, 0, 5, 6);
    cfg(5, ABS, -t, 0, 0, 0, 1, -2, 0, 0, 0, 0);
    startSeq();
    checkBlock(1, 0, 1'b0);
    waitStart();
    checkBlock(2, 0, 1'b0);
    `CHK(waited >= 30 && waited <= 45, 1'b1)
    @(negedge clock);
    {event1Pin, event2Pin} = 2'b11;
    waitStart();
    // set between edges: the partner loads it at the coming falling edge
    reachDelay = 16'd300;
    checkBlock(3, 0, 1'b0);
    @(negedge clock);
    {event1Pin, event2Pin} = 2'b00;
    {intEvent1Pin, intEvent2Pin} = 2'b11;
    waitStart();
    reachDelay = 16'd5;
    `CHK(moveAbort, 1'b1)
    checkBlock(5, 0, 1'b0);
    @(negedge clock);
    {intEvent1Pin, intEvent2Pin} = 2'b00;
    for (i = 0; i < 300 && faultAction === 2'b00; i++) @(negedge clock);
    `CHK({faultAction, busy}, 3'b100)
    $display("TB: transitions done");
    // ************ repetitions ************
    cfg(1, 4'($urandom_range(1, 3)), t, 0, 0, 2, 2, 0, 2, 0, 0, 0);
    cfg(2, ABS, t, 0, 0, 3, 0, 0, 0, 0, 0, 0);
    {lastWasManualJogMove, actualPosition} = {1'b1, -32'sd5000};
    startSeq();
    checkBlock(1, -5000, 1'b1);
    {lastWasManualJogMove, event1Pin} = 2'b01;
    for (i = 0; i < 2; i++) begin
      waitStart();
      checkBlock(1, 0, 1'b0);
      `CHK(waited >= 20, 1'b1)
    end
    waitStart();
    checkBlock(2, 0, 1'b0);
    @(negedge clock);
    event1Pin = 1'b0;
    repeat (60) @(negedge clock);
    `CHK({busy, activeBlock}, 7'h00)
    $display("TB: repetitions done");
    // ************ early event and restart ************
    cfg(1, ABS, t, 0, 0, 0, 100, 2, 0, 3, 0, 0);
    cfg(3, ABS, -t, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    startSeq();
    checkBlock(1, 0, 1'b0);
    repeat (60) @(negedge clock);
    {event2Pin, opMode} = {1'b1, 3'b110};
    waitStart();
    checkBlock(3, 0, 1'b0);
    `CHK(waited < 100, 1'b1)
    @(negedge clock);
    event2Pin = 1'b0;
    waitStart();
    checkBlock(1, 0, 1'b0);
    $display("TB: restart done");
    endOfTest();
  end
endmodule
